// *** logic/synth_ctrl_host.sv ***
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "synth_ctrl_regs.svh"
module synth_ctrl_host
    import synth_ctrl_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    synth_serial_if.host link
);
    link_state_t state_q, state_d;
    logic wr_pend_q, wr_pend_d;
    logic [7:0] addr_q, addr_d;
    logic [31:0] rdata_q, rdata_d;
    logic [15:0] div_q, div_d;
    logic [15:0] cnt_q, cnt_d;
    word_t sh_q, sh_d;
    logic [4:0] bit_q, bit_d;
    logic sclk_q, sclk_d;
    logic le_q, le_d;
    logic warn_q, warn_d;
    logic pend_q, pend_d;
    logic presc_q, presc_d;
    logic pol_q, pol_d;
    logic tick;
    logic busy;
    logic take;
    word_t w;
    logic [31:0] status;

    assign busy = (state_q != ST_IDLE);
    assign tick = (cnt_q == div_q);
    assign take = i_hsel & i_htrans[1] & i_hready;
    assign status = {29'h0, pend_q, warn_q, busy};

    always_comb begin
        wr_pend_d = take & i_hwrite;
        addr_d = take ? i_haddr[7:0] : addr_q;
        rdata_d = rdata_q;
        if (take && !i_hwrite) begin
            unique case (i_haddr[7:0])
                `ADDR_STATUS: rdata_d = status;
                `ADDR_DIV: rdata_d = {16'h0000, div_q};
                default: rdata_d = 32'h0000_0000;
            endcase
        end
        div_d = div_q;
        cnt_d = (busy && !tick) ? cnt_q + 16'h0001 : 16'h0000;
        state_d = state_q;
        sh_d = sh_q;
        bit_d = bit_q;
        sclk_d = sclk_q;
        le_d = le_q;
        warn_d = warn_q;
        pend_d = pend_q;
        presc_d = presc_q;
        pol_d = pol_q;
        w = i_hwdata;
        if (wr_pend_q && addr_q == `ADDR_STATUS && i_hwdata[`STAT_WARN]) begin
            warn_d = 1'b0;
        end
        if (wr_pend_q && addr_q == `ADDR_DIV) begin
            div_d = i_hwdata[15:0];
        end
        // a word written while busy is dropped
        if (wr_pend_q && addr_q == `ADDR_TX && !busy) begin
            unique case (w[`SEL_HI:`SEL_LO])
                `CODE_INT_WORD: begin
                    pend_d = 1'b0;
                    if (w[`IW_INT_HI:`IW_INT_LO] < (presc_q ? `INT_MIN_89 : `INT_MIN_45)) begin
                        warn_d = 1'b1;
                    end
                end
                `CODE_LSB_WORD: begin
                    w[`LW_RSV_HI:`LW_RSV_LO] = 3'h0;
                    if (!w[`LW_PHADJ]) begin
                        w[`LW_PHASE_HI:`LW_PHASE_LO] = 12'h000;
                    end
                    pend_d = 1'b1;
                end
                `CODE_REF_WORD: begin
                    w[`RW_RSV_HI:`RW_RSV_LO] = 3'h0;
                    w[`RW_RSV_MID] = 1'b0;
                    presc_d = w[`RW_PRESC];
                    if (w[`RW_SLIP] && (w[`RW_CP_HI:`RW_CP_LO] != 4'h0 || !pol_q)) begin
                        warn_d = 1'b1;
                    end
                    pend_d = 1'b1;
                end
                `CODE_FUNC_WORD: pol_d = w[`FW_POL];
                default: ;
            endcase
            sh_d = w;
            bit_d = 5'h1F;
            state_d = ST_LOW;
        end
        if (busy && tick) begin
            unique case (state_q)
                ST_LOW: begin
                    sclk_d = 1'b1;
                    state_d = ST_HIGH;
                end
                ST_HIGH: begin
                    sclk_d = 1'b0;
                    if (bit_q == 5'h00) begin
                        le_d = 1'b1;
                        state_d = ST_LOAD;
                    end else begin
                        sh_d = {sh_q[30:0], 1'b0};
                        bit_d = bit_q - 5'h01;
                        state_d = ST_LOW;
                    end
                end
                ST_LOAD: begin
                    le_d = 1'b0;
                    state_d = ST_IDLE;
                end
                default: state_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_q <= ST_IDLE;
            wr_pend_q <= 1'b0;
            addr_q <= 8'h00;
            rdata_q <= 32'h0000_0000;
            div_q <= `DIV_RESET;
            cnt_q <= 16'h0000;
            sh_q <= 32'h0000_0000;
            bit_q <= 5'h00;
            sclk_q <= 1'b0;
            le_q <= 1'b0;
            warn_q <= 1'b0;
            pend_q <= 1'b0;
            presc_q <= 1'b0;
            pol_q <= 1'b0;
        end else begin
            state_q <= state_d;
            wr_pend_q <= wr_pend_d;
            addr_q <= addr_d;
            rdata_q <= rdata_d;
            div_q <= div_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            bit_q <= bit_d;
            sclk_q <= sclk_d;
            le_q <= le_d;
            warn_q <= warn_d;
            pend_q <= pend_d;
            presc_q <= presc_d;
            pol_q <= pol_d;
        end
    end

    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign o_hrdata = rdata_q;
    assign link.ser_clk = sclk_q;
    assign link.ser_data = sh_q[31];
    assign link.load_en = le_q;
endmodule // synth_ctrl_host

// *** logic/synth_ctrl_regs.svh ***
`ifndef SYNTH_CTRL_REGS_SVH
`define SYNTH_CTRL_REGS_SVH

// register select code in the low bits of every word
`define SEL_HI 2
`define SEL_LO 0
`define CODE_INT_WORD 3'h0
`define CODE_LSB_WORD 3'h1
`define CODE_REF_WORD 3'h2
`define CODE_FUNC_WORD 3'h3

// fractional/integer word
`define IW_RAMP 31
`define IW_MUX_HI 30
`define IW_MUX_LO 27
`define IW_INT_HI 26
`define IW_INT_LO 15
`define IW_FMSB_HI 14
`define IW_FMSB_LO 3

// fractional lsb / phase word
`define LW_RSV_HI 31
`define LW_RSV_LO 29
`define LW_PHADJ 28
`define LW_FLSB_HI 27
`define LW_FLSB_LO 15
`define LW_PHASE_HI 14
`define LW_PHASE_LO 3

// reference divider word
`define RW_RSV_HI 31
`define RW_RSV_LO 29
`define RW_SLIP 28
`define RW_CP_HI 27
`define RW_CP_LO 24
`define RW_RSV_MID 23
`define RW_PRESC 22
`define RW_HALVE 21
`define RW_DOUBLE 20
`define RW_RCNT_HI 19
`define RW_RCNT_LO 15
`define RW_CLK1_HI 14
`define RW_CLK1_LO 3

// function word detector polarity
`define FW_POL 6

// deviation, step and delay words
`define DW_CHOICE 23
`define DW_OFS_HI 22
`define DW_OFS_LO 19
`define DW_DEV_HI 18
`define DW_DEV_LO 3
`define SW_CHOICE 23
`define SW_STEP_HI 22
`define SW_STEP_LO 3
`define YW_START_EN 15
`define YW_DLY_HI 14
`define YW_DLY_LO 3

// least integer values per prescaler
`define INT_MIN_45 12'h017
`define INT_MIN_89 12'h04B

// controller registers on the AHB-Lite side
`define ADDR_TX 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_DIV 8'h08
`define STAT_BUSY 0
`define STAT_WARN 1
`define STAT_PEND 2
`define DIV_RESET 16'h0004

`endif

// *** logic/synth_ctrl_pkg.sv ***
package synth_ctrl_pkg;

    typedef logic [31:0] word_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW = 2'b01,
        ST_HIGH = 2'b11,
        ST_LOAD = 2'b10
    } link_state_t;

endpackage

// *** logic/synth_serial_if.sv ***
`timescale 1ns/1ps
interface synth_serial_if;
    logic ser_clk;
    logic ser_data;
    logic load_en;

    modport device (
        input ser_clk,
        input ser_data,
        input load_en
    );

    modport host (
        output ser_clk,
        output ser_data,
        output load_en
    );
endinterface

// *** logic/serial_word_shifter.sv ***
`timescale 1ns/1ps
module serial_word_shifter
    import synth_ctrl_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic i_shift_en,
    input wire logic i_bit,
    output word_t o_word
);
    word_t word_q;
    word_t word_d;

    // msb first: each new bit enters at bit 0
    always_comb begin
        word_d = word_q;
        if (i_shift_en) begin
            word_d = {word_q[30:0], i_bit};
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            word_q <= 32'h0000_0000;
        end else begin
            word_q <= word_d;
        end
    end

    assign o_word = word_q;
endmodule // serial_word_shifter

// *** logic/synth_ctrl_device.sv ***
// Notes on behaviour
// - low three bits pick the target register
// - word0 bit31 enables the frequency ramp
// - word0 bits30..27 select monitor output source
// - word0 bits26..15 are integer divide value
// - fraction is msb12 times 8192 plus lsb13
// - host zeroes reserved bits of words 1,2
// - word1 bit28 enables phase adjustment
// - phase word advances phase at next word0
// - unused phase word preferably written as zero
// - word2 bit28 enables cycle slip reduction
// - slip reduction needs positive polarity, minimum current
// - word2 bits27..24 set charge pump current
// - word2 bit22 picks prescaler, 8/9 above 8GHz
// - integer at least 23 or 75 per prescaler
// - word2 bit21 inserts reference halver stage
// - buffered settings apply on next word0 write
`timescale 1ns/1ps
`include "synth_ctrl_regs.svh"
module synth_ctrl_device
    import synth_ctrl_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    synth_serial_if.device link,
    output logic o_ramp_enable,
    output logic [3:0] o_monitor_output_select,
    output logic [11:0] o_integer_value,
    output logic [24:0] o_fractional_divide_value,
    output logic o_phase_adjust_enable,
    output logic [11:0] o_phase_word,
    output logic o_phase_advance,
    output logic o_divider_update,
    output logic o_cycle_slip_reduction,
    output logic [3:0] o_charge_pump_current,
    output logic o_prescaler_8_9,
    output logic o_reference_halver,
    output logic o_reference_doubler,
    output logic [4:0] o_reference_count,
    output logic [11:0] o_step_clock_divider,
    output word_t o_function_word,
    output word_t o_clock_word,
    output word_t o_deviation_word,
    output logic [15:0] o_deviation_value,
    output logic [3:0] o_deviation_offset,
    output logic o_deviation_choice,
    output word_t o_ramp_step_word,
    output logic [19:0] o_step_value,
    output logic o_step_choice,
    output word_t o_ramp_delay_word,
    output logic [11:0] o_delay_start_value,
    output logic o_delayed_start_enable
);
    word_t shift_word;
    word_t word_q [8];
    word_t word_d [8];
    logic sclk_prev_q;
    logic le_prev_q;
    logic shift_en;
    logic load;
    logic [2:0] sel;

    // double-buffered copies in use
    logic [12:0] act_fraction_lsb_q, act_fraction_lsb_d;
    logic [11:0] act_phase_q, act_phase_d;
    logic [3:0] act_cp_q, act_cp_d;
    logic act_halve_q, act_halve_d;
    logic act_double_q, act_double_d;
    logic [4:0] act_rcnt_q, act_rcnt_d;
    logic [11:0] act_clk1_q, act_clk1_d;
    logic phase_step_q, phase_step_d;
    logic update_q, update_d;

    assign shift_en = link.ser_clk & ~sclk_prev_q;
    assign load = link.load_en & ~le_prev_q;
    assign sel = shift_word[`SEL_HI:`SEL_LO];

    serial_word_shifter u_shifter (
        .i_clock(i_clock),
        .i_rst_n(i_rst_n),
        .i_shift_en(shift_en),
        .i_bit(link.ser_data),
        .o_word(shift_word)
    );

    always_comb begin
        word_d = word_q;
        act_fraction_lsb_d = act_fraction_lsb_q;
        act_phase_d = act_phase_q;
        act_cp_d = act_cp_q;
        act_halve_d = act_halve_q;
        act_double_d = act_double_q;
        act_rcnt_d = act_rcnt_q;
        act_clk1_d = act_clk1_q;
        phase_step_d = 1'b0;
        update_d = 1'b0;
        if (load) begin
            word_d[sel] = shift_word;
            if (sel == `CODE_INT_WORD) begin
                update_d = 1'b1;
                // staged fields of words 1,2 take effect only now
                act_fraction_lsb_d = word_q[1][`LW_FLSB_HI:`LW_FLSB_LO];
                act_phase_d = word_q[1][`LW_PHASE_HI:`LW_PHASE_LO];
                act_cp_d = word_q[2][`RW_CP_HI:`RW_CP_LO];
                act_halve_d = word_q[2][`RW_HALVE];
                act_double_d = word_q[2][`RW_DOUBLE];
                act_rcnt_d = word_q[2][`RW_RCNT_HI:`RW_RCNT_LO];
                act_clk1_d = word_q[2][`RW_CLK1_HI:`RW_CLK1_LO];
                phase_step_d = word_q[1][`LW_PHADJ];
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < 8; i++) begin
                word_q[i] <= 32'h0000_0000;
            end
            sclk_prev_q <= 1'b0;
            le_prev_q <= 1'b0;
            act_fraction_lsb_q <= 13'h0000;
            act_phase_q <= 12'h000;
            act_cp_q <= 4'h0;
            act_halve_q <= 1'b0;
            act_double_q <= 1'b0;
            act_rcnt_q <= 5'h00;
            act_clk1_q <= 12'h000;
            phase_step_q <= 1'b0;
            update_q <= 1'b0;
        end else begin
            word_q <= word_d;
            sclk_prev_q <= link.ser_clk;
            le_prev_q <= link.load_en;
            act_fraction_lsb_q <= act_fraction_lsb_d;
            act_phase_q <= act_phase_d;
            act_cp_q <= act_cp_d;
            act_halve_q <= act_halve_d;
            act_double_q <= act_double_d;
            act_rcnt_q <= act_rcnt_d;
            act_clk1_q <= act_clk1_d;
            phase_step_q <= phase_step_d;
            update_q <= update_d;
        end
    end

    assign o_ramp_enable = word_q[0][`IW_RAMP];
    assign o_monitor_output_select = word_q[0][`IW_MUX_HI:`IW_MUX_LO];
    assign o_integer_value = word_q[0][`IW_INT_HI:`IW_INT_LO];
    assign o_fractional_divide_value =
        {word_q[0][`IW_FMSB_HI:`IW_FMSB_LO], act_fraction_lsb_q};
    assign o_phase_adjust_enable = word_q[1][`LW_PHADJ];
    assign o_phase_word = act_phase_q;
    assign o_phase_advance = phase_step_q;
    assign o_divider_update = update_q;
    assign o_cycle_slip_reduction = word_q[2][`RW_SLIP];
    assign o_charge_pump_current = act_cp_q;
    assign o_prescaler_8_9 = word_q[2][`RW_PRESC];
    assign o_reference_halver = act_halve_q;
    assign o_reference_doubler = act_double_q;
    assign o_reference_count = act_rcnt_q;
    assign o_step_clock_divider = act_clk1_q;
    assign o_function_word = word_q[3];
    assign o_clock_word = word_q[4];
    assign o_deviation_word = word_q[5];
    assign o_deviation_value = word_q[5][`DW_DEV_HI:`DW_DEV_LO];
    assign o_deviation_offset = word_q[5][`DW_OFS_HI:`DW_OFS_LO];
    assign o_deviation_choice = word_q[5][`DW_CHOICE];
    assign o_ramp_step_word = word_q[6];
    assign o_step_value = word_q[6][`SW_STEP_HI:`SW_STEP_LO];
    assign o_step_choice = word_q[6][`SW_CHOICE];
    assign o_ramp_delay_word = word_q[7];
    assign o_delay_start_value = word_q[7][`YW_DLY_HI:`YW_DLY_LO];
    assign o_delayed_start_enable = word_q[7][`YW_START_EN];
endmodule // synth_ctrl_device

// *** bench/synth_ctrl_assertions.sv ***
`timescale 1ns/1ps
module synth_ctrl_assertions
    import synth_ctrl_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic load_en,
    input wire logic o_ramp_enable,
    input wire logic [3:0] o_monitor_output_select,
    input wire logic [11:0] o_integer_value,
    input wire logic [24:0] o_fractional_divide_value,
    input wire logic o_phase_advance,
    input wire logic o_divider_update,
    input wire logic o_cycle_slip_reduction,
    input wire logic [3:0] o_charge_pump_current,
    input wire logic o_prescaler_8_9
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);

    // shadow copy of the word on the wire
    word_t sh_q;
    logic clk_q;
    logic ld_q;
    logic ld0;
    logic ld2;
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sh_q <= '0;
            clk_q <= 1'h0;
            ld_q <= 1'h0;
        end else begin
            clk_q <= ser_clk;
            ld_q <= load_en;
            if (ser_clk && !clk_q) begin
                sh_q <= {sh_q[30:0], ser_data};
            end
        end
    end
    assign ld0 = load_en && !ld_q && (sh_q[2:0] == 3'h0);
    assign ld2 = load_en && !ld_q && (sh_q[2:0] == 3'h2);

    property p_update_pulse; ld0 |=> o_divider_update; endproperty
    a_update_pulse: assert property (p_update_pulse) else $error("no update pulse");
    property p_update_cause; o_divider_update |-> $past(ld0); endproperty
    a_update_cause: assert property (p_update_cause) else $error("stray update");
    property p_ramp; ld0 |=> o_ramp_enable == $past(sh_q[31]); endproperty
    a_ramp: assert property (p_ramp) else $error("ramp enable wrong");
    property p_mux; ld0 |=> o_monitor_output_select == $past(sh_q[30:27]); endproperty
    a_mux: assert property (p_mux) else $error("monitor select wrong");
    property p_int; ld0 |=> o_integer_value == $past(sh_q[26:15]); endproperty
    a_int: assert property (p_int) else $error("integer value wrong");
    property p_fraction_msb;
        ld0 |=> o_fractional_divide_value[24:13] == $past(sh_q[14:3]);
    endproperty
    a_fraction_msb: assert property (p_fraction_msb) else $error("fraction msb wrong");
    property p_slip; ld2 |=> o_cycle_slip_reduction == $past(sh_q[28]); endproperty
    a_slip: assert property (p_slip) else $error("slip reduction wrong");
    property p_presc; ld2 |=> o_prescaler_8_9 == $past(sh_q[22]); endproperty
    a_presc: assert property (p_presc) else $error("prescaler wrong");
    property p_cp_held; ld2 |=> $stable(o_charge_pump_current); endproperty
    a_cp_held: assert property (p_cp_held) else $error("pump current early");
    property p_phase_pulse; o_phase_advance |-> o_divider_update; endproperty
    a_phase_pulse: assert property (p_phase_pulse) else $error("phase step alone");
    property p_load_idle; load_en |-> !ser_clk; endproperty
    a_load_idle: assert property (p_load_idle) else $error("clock during load");
endmodule // synth_ctrl_assertions

// *** bench/synth_control_register_bank_tb_top.sv ***
`timescale 1ns/1ps
module synth_control_register_bank_tb_top
    import synth_ctrl_pkg::*;
;
    logic i_clock = 1'h0;
    logic i_rst_n = 1'h0;
    logic i_hsel = 1'h1;
    logic [31:0] i_haddr = '0;
    logic [1:0] i_htrans = 2'h0;
    logic i_hwrite = 1'h0;
    logic [2:0] i_hsize = 3'h2;
    logic [31:0] i_hwdata = '0;
    logic i_hready, o_hreadyout, o_hresp;
    logic [31:0] o_hrdata;
    word_t o_function_word, o_clock_word, o_deviation_word, o_ramp_step_word, o_ramp_delay_word;
    logic o_ramp_enable, o_phase_adjust_enable, o_phase_advance, o_divider_update;
    logic o_cycle_slip_reduction, o_prescaler_8_9, o_reference_halver, o_reference_doubler;
    logic o_deviation_choice, o_step_choice, o_delayed_start_enable;
    logic [3:0] o_monitor_output_select, o_charge_pump_current, o_deviation_offset;
    logic [11:0] o_integer_value, o_phase_word, o_step_clock_divider, o_delay_start_value;
    logic [24:0] o_fractional_divide_value;
    logic [4:0] o_reference_count;
    logic [15:0] o_deviation_value;
    logic [19:0] o_step_value;
    int errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int upd_n = 0;
    int adv_n = 0;
    word_t wire_w, sh, rd;
    logic ck_q;
    typedef struct { logic snd; word_t w; int k; word_t e; } row_t;
    row_t rows [12] = '{
        '{1'h1, 32'h0000_0043, 4, 32'h0000_0043},
        '{1'h1, {3'h0, 1'h1, 13'h1ABC, 12'h200, 3'h1}, 2, {1'h1, 12'h000}},
        '{1'h1, {3'h0, 1'h1, 4'h0, 4'h7, 5'h05, 12'h0AB, 3'h2}, 3, {6'h21, 7'h00}},
        '{1'h1, {1'h1, 4'hA, 12'h04B, 12'h123, 3'h0}, 0, {1'h1, 4'hA, 12'h04B}},
        '{1'h0, '0, 1, {12'h123, 13'h1ABC}},
        '{1'h0, '0, 2, {1'h1, 12'h200}},
        '{1'h0, '0, 3, {6'h21, 2'h3, 5'h05}},
        '{1'h0, '0, 8, 32'h0000_00AB},
        '{1'h1, {8'h0, 1'h1, 4'h9, 16'hBEEF, 3'h5}, 5, {1'h1, 4'h9, 16'hBEEF}},
        '{1'h1, {8'h0, 1'h1, 20'hABCDE, 3'h6}, 6, {1'h1, 20'hABCDE}},
        '{1'h1, {16'h0, 1'h1, 12'h5A5, 3'h7}, 7, {1'h1, 12'h5A5}},
        '{1'h1, 32'h1234_5674, 9, 32'h1234_5674}
    };

    assign i_hready = o_hreadyout;
    synth_serial_if sif();
    synth_ctrl_host synth_ctrl_host_inst (.*, .link(sif.host));
    synth_ctrl_device synth_ctrl_device_inst (.*, .link(sif.device));
    synth_ctrl_assertions synth_ctrl_assertions_inst (.*, .ser_clk(sif.ser_clk),
        .ser_data(sif.ser_data), .load_en(sif.load_en));

    always #10 i_clock = ~i_clock;

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // wire-side capture and pulse counting
    always @(posedge i_clock) begin
        cycles++;
        ck_q <= sif.ser_clk;
        if (sif.ser_clk && !ck_q) sh <= {sh[30:0], sif.ser_data};
        if (sif.load_en) wire_w <= sh;
        if (o_divider_update === 1'h1) upd_n++;
        if (o_phase_advance === 1'h1) adv_n++;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end

    task automatic check(input string what, input logic [31:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input word_t d);
        i_haddr <= {24'h0, a};
        i_htrans <= 2'h2;
        i_hwrite <= wr;
        @(posedge i_clock);
        while (i_hready !== 1'h1) @(posedge i_clock);
        i_htrans <= 2'h0;
        i_hwdata <= d;
        @(posedge i_clock);
        while (i_hready !== 1'h1) @(posedge i_clock);
        rd = o_hrdata;
    endtask

    task automatic send(input word_t w);
        ahb(1'h1, 8'h00, w);
        // a hung link is caught by the cycle ceiling
        do begin
            ahb(1'h0, 8'h04, '0);
        end while (rd[0] !== 1'h0);
        repeat (3) @(posedge i_clock);
    endtask

    function automatic word_t obs(input int k);
        case (k)
            0: return {o_ramp_enable, o_monitor_output_select, o_integer_value};
            1: return o_fractional_divide_value;
            2: return {o_phase_adjust_enable, o_phase_word};
            3: return {o_cycle_slip_reduction, o_charge_pump_current, o_prescaler_8_9,
                o_reference_halver, o_reference_doubler, o_reference_count};
            4: return o_function_word;
            5: return {o_deviation_choice, o_deviation_offset, o_deviation_value};
            6: return {o_step_choice, o_step_value};
            7: return {o_delayed_start_enable, o_delay_start_value};
            8: return o_step_clock_divider;
            default: return o_clock_word;
        endcase
    endfunction

    initial begin
        repeat (8) @(posedge i_clock);
        i_rst_n <= 1'h1;
        @(posedge i_clock);
        ahb(1'h0, 8'h08, '0);
        check("divider reset", rd, 32'h0000_0004);
        ahb(1'h1, 8'h08, '0);
        foreach (rows[i]) begin
            if (rows[i].snd) begin
                send(rows[i].w);
                check("wire word", wire_w, rows[i].w);
            end
            check($sformatf("row %0d", i), obs(rows[i].k), rows[i].e);
        end
        check("updates", upd_n, 1);
        check("phase steps", adv_n, 1);
        ahb(1'h0, 8'h04, '0);
        check("warn clear", rd[1], 1'h0);
        // reserved bits set and unused phase word on the user side
        send({3'h7, 1'h0, 13'h0002, 12'hFFF, 3'h1});
        check("wire reserved", wire_w, {3'h0, 1'h0, 13'h0002, 12'h000, 3'h1});
        check("phase enable", o_phase_adjust_enable, 1'h0);
        check("lsb held", obs(1), {12'h123, 13'h1ABC});
        // integer below the 8/9 minimum
        send({1'h0, 4'h3, 12'h04A, 12'h7FF, 3'h0});
        check("fractional_divide_value new", obs(1), {12'h7FF, 13'h0002});
        check("phase word", obs(2), 32'h0000_0000);
        check("updates2", upd_n, 2);
        check("phase steps2", adv_n, 1);
        ahb(1'h0, 8'h04, '0);
        check("warn set", rd[1], 1'h1);
        ahb(1'h1, 8'h04, 32'h0000_0002);
        ahb(1'h0, 8'h04, '0);
        check("warn cleared", rd[1], 1'h0);
        // second word while busy is dropped
        ahb(1'h1, 8'h00, {5'h00, 12'h100, 12'h000, 3'h0});
        send({5'h00, 12'h200, 12'h000, 3'h0});
        check("busy drop", o_integer_value, 12'h100);
        check("busy wire", wire_w, {5'h00, 12'h100, 12'h000, 3'h0});
        ahb(1'h0, 8'h0C, '0);
        check("unmapped", rd, 32'h0000_0000);
        // slip reduction with pump current above minimum, then integer at the 4/5 floor
        send({3'h0, 1'h1, 4'h5, 4'h0, 5'h00, 12'h000, 3'h2});
        check("slip staged", obs(3), {1'h1, 4'h0, 1'h0, 2'h3, 5'h05});
        ahb(1'h0, 8'h04, '0);
        check("slip warn", rd, 32'h0000_0006);
        ahb(1'h1, 8'h04, 32'h0000_0002);
        send({5'h00, 12'h017, 12'h000, 3'h0});
        check("pump applied", obs(3), {1'h1, 4'h5, 1'h0, 2'h0, 5'h00});
        ahb(1'h0, 8'h04, '0);
        check("status idle", rd, 32'h0000_0000);
        // reset in mid-run
        i_rst_n <= 1'h0;
        repeat (2) @(posedge i_clock);
        check("reset int", obs(0), 32'h0000_0000);
        check("reset lsb", obs(1), 32'h0000_0000);
        i_rst_n <= 1'h1;
        @(posedge i_clock);
        ahb(1'h0, 8'h08, '0);
        check("divider after reset", rd, 32'h0000_0004);
        finish_test();
    end
endmodule // synth_control_register_bank_tb_top
